// File: hw/tdt_core.sv
module tdt_core
   import tdt_pkg::*;
#(
   parameter int TICK_CY = TICK_CYCLES
) (
   input  wire logic             clk_sys,
   input  wire logic             resetn,
   input  wire logic             clk_en,
   input  wire logic             reg_wr,
   input  wire logic [9:0]       reg_addr,
   input  wire logic [7:0]       reg_wdata,
   output logic      [7:0]       reg_rdata,
   input  wire logic             acq_strobe,
   input  wire logic [NCH-1:0]   ch_over_thr,
   input  wire logic [NCH-1:0]   ch_neg_cross,
   input  wire logic [NCH-1:0]   ch_guard,
   input  wire logic [NCH-1:0]   ch_on_object,
   input  wire logic             object_touched,
   input  wire logic [NCH-1:0]   host_recal,
   output logic      [NCH-1:0]   ch_detect,
   output logic      [NCH-1:0]   ch_filter_run,
   output logic      [NCH-1:0]   ch_recal,
   output logic      [NCH-1:0]   drift_enable,
   output logic      [7:0]       force_on_pct,
   output logic      [7:0]       force_off_pct,
   input  wire logic             high_speed,
   output logic      [7:0]       dwell_cycles,
   input  wire logic             coord_valid,
   input  wire logic             coord_is_screen,
   input  wire logic [15:0]      raw_x,
   input  wire logic [15:0]      raw_y,
   output logic      [9:0]       pos_x,
   output logic      [9:0]       pos_y,
   output logic                  pos_update,
   input  wire logic [6:0]       status_change,
   output logic                  change_req
);

   // ------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------
   logic [7:0] normal_integrator_limit_q, short_integrator_limit_q, recal_q, dhold_q, force_q;
   logic [7:0] clipx_q, clipy_q, dwell_q, evmask_q;
   logic [15:0] ofsx_q, ofsy_q;
   logic [7:0] segx_q [NSEG];
   logic [7:0] segy_q [NSEG];

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         normal_integrator_limit_q   <= RST_NORMAL_INTEGRATOR_LIMIT;
         short_integrator_limit_q   <= RST_SHORT_INTEGRATOR_LIMIT;
         recal_q  <= RST_RECAL;
         dhold_q  <= RST_DHOLD;
         force_q  <= RST_FORCE;
         clipx_q  <= 8'h00;
         clipy_q  <= 8'h00;
         ofsx_q   <= 16'h0000;
         ofsy_q   <= 16'h0000;
         dwell_q  <= RST_DWELL;
         evmask_q <= RST_EVMASK;
         for (int i = 0; i < NSEG; i++) begin
            segx_q[i] <= RST_SEG;
            segy_q[i] <= RST_SEG;
         end
      end else if (clk_en && reg_wr) begin
         case (reg_addr)
            A_NORMAL_INTEGRATOR_LIMIT:    normal_integrator_limit_q         <= reg_wdata;
            A_SHORT_INTEGRATOR_LIMIT:    short_integrator_limit_q         <= reg_wdata;
            A_RECAL:   recal_q        <= reg_wdata;
            A_DHOLD:   dhold_q        <= reg_wdata;
            A_FORCE:   force_q        <= reg_wdata;
            A_CLIPX:   clipx_q        <= reg_wdata;
            A_CLIPY:   clipy_q        <= reg_wdata;
            A_OFSX_LO: ofsx_q[7:0]    <= reg_wdata;
            A_OFSX_HI: ofsx_q[15:8]   <= reg_wdata;
            A_OFSY_LO: ofsy_q[7:0]    <= reg_wdata;
            A_OFSY_HI: ofsy_q[15:8]   <= reg_wdata;
            A_DWELL:   dwell_q        <= reg_wdata;
            A_EVMASK:  evmask_q       <= reg_wdata;
            default: begin
               if (reg_addr >= A_SEGX && reg_addr < A_SEGX + 10'(NSEG))
                  segx_q[4'(reg_addr - A_SEGX)] <= reg_wdata;
               if (reg_addr >= A_SEGY && reg_addr < A_SEGY + 10'(NSEG))
                  segy_q[4'(reg_addr - A_SEGY)] <= reg_wdata;
            end
         endcase
      end
   end

   // readback is combinational from the register file; unmapped reads zero
   always_comb begin
      reg_rdata = 8'h00;
      case (reg_addr)
         A_NORMAL_INTEGRATOR_LIMIT:    reg_rdata = normal_integrator_limit_q;
         A_SHORT_INTEGRATOR_LIMIT:    reg_rdata = short_integrator_limit_q;
         A_RECAL:   reg_rdata = recal_q;
         A_DHOLD:   reg_rdata = dhold_q;
         A_FORCE:   reg_rdata = force_q;
         A_CLIPX:   reg_rdata = clipx_q;
         A_CLIPY:   reg_rdata = clipy_q;
         A_OFSX_LO: reg_rdata = ofsx_q[7:0];
         A_OFSX_HI: reg_rdata = ofsx_q[15:8];
         A_OFSY_LO: reg_rdata = ofsy_q[7:0];
         A_OFSY_HI: reg_rdata = ofsy_q[15:8];
         A_DWELL:   reg_rdata = dwell_q;
         A_EVMASK:  reg_rdata = evmask_q;
         default: begin
            if (reg_addr >= A_SEGX && reg_addr < A_SEGX + 10'(NSEG))
               reg_rdata = segx_q[4'(reg_addr - A_SEGX)];
            if (reg_addr >= A_SEGY && reg_addr < A_SEGY + 10'(NSEG))
               reg_rdata = segy_q[4'(reg_addr - A_SEGY)];
         end
      endcase
   end

   // ------------------------------------------------------------
   // 0.2 s time base
   // ------------------------------------------------------------
   logic [31:0] tick_cnt_q;
   logic        tick;

   assign tick = (tick_cnt_q == 32'(TICK_CY - 1));

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn)
         tick_cnt_q <= '0;
      else if (clk_en)
         tick_cnt_q <= tick ? '0 : tick_cnt_q + 32'd1;
   end

   // ------------------------------------------------------------
   // per-channel integrator and recalibration
   // ------------------------------------------------------------
   logic [NCH-1:0] new_detect;

   for (genvar c = 0; c < NCH; c++) begin : g_ch
      logic [7:0] integ_q, integ_d, limit;
      logic [7:0] rtime_q;
      logic       det_q, recal_fire;

      assign limit   = (object_touched && ch_on_object[c]) ? short_integrator_limit_q : normal_integrator_limit_q;
      // saturate so a long touch cannot wrap back under the limit
      assign integ_d = ch_over_thr[c] ? ((integ_q == 8'hFF) ? integ_q : integ_q + 8'd1)
                                      : 8'h00;
      // guards are exempt from timed recal, host_recal still fires; delay zero means never
      assign recal_fire = host_recal[c]
                        || (det_q && !ch_guard[c] && recal_q != 8'h00 && tick && rtime_q + 8'd1 >= recal_q);

      always_ff @(posedge clk_sys or negedge resetn) begin
         if (!resetn) begin
            integ_q <= 8'h00;
            det_q   <= 1'b0;
         end else if (clk_en) begin
            if (recal_fire) begin
               integ_q <= 8'h00;
               det_q   <= 1'b0;
            end else if (acq_strobe) begin
               integ_q <= integ_d;
               det_q   <= ch_over_thr[c] && integ_d >= limit && limit != 8'h00;
            end
         end
      end

      always_ff @(posedge clk_sys or negedge resetn) begin
         if (!resetn)
            rtime_q <= 8'h00;
         else if (clk_en) begin
            if (!det_q || recal_fire)
               rtime_q <= 8'h00;
            else if (tick && rtime_q != 8'hFF)
               rtime_q <= rtime_q + 8'd1;
         end
      end

      always_ff @(posedge clk_sys or negedge resetn) begin
         if (!resetn)
            ch_recal[c] <= 1'b0;
         else if (clk_en)
            ch_recal[c] <= recal_fire;
      end

      assign ch_detect[c]     = det_q;
      assign ch_filter_run[c] = ch_on_object[c] && integ_q >= short_integrator_limit_q && integ_q != 8'h00;
      assign new_detect[c]    = clk_en && acq_strobe && !det_q && !recal_fire
                                && ch_over_thr[c] && integ_d >= limit && limit != 8'h00;
   end

   // ------------------------------------------------------------
   // drift hold
   // ------------------------------------------------------------
   logic [7:0] hold_q;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn)
         hold_q <= 8'h00;
      else if (clk_en) begin
         if (|new_detect)
            hold_q <= dhold_q;
         else if (tick && hold_q != 8'h00)
            hold_q <= hold_q - 8'd1;
      end
   end

   // hold counter reloads on any new detection, so all channels freeze together
   assign drift_enable = (hold_q == 8'h00 && ~|ch_detect) ? ~ch_neg_cross : '0;

   // ------------------------------------------------------------
   // force thresholds and dwell
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         force_on_pct  <= 8'h00;
         force_off_pct <= 8'h00;
         dwell_cycles  <= 8'h00;
      end else if (clk_en) begin
         force_on_pct  <= FORCE_PCT[force_q[FORCE_ON_LSB +: 4]];
         force_off_pct <= FORCE_PCT[force_q[FORCE_ON_LSB +: 4]] + FORCE_PCT[force_q[3:0]];
         // codes above five are unspecified; treat as the one-microsecond default
         if (dwell_q < 8'(DWELL_CODES))
            dwell_cycles <= 8'(DWELL_HALF_CY) * 8'(high_speed ? DWELL_HS[3'(dwell_q)]
                                                               : DWELL_LS[3'(dwell_q)]);
         else
            dwell_cycles <= 8'(DWELL_HALF_CY) * 8'(DWELL_HS[0]);
      end
   end

   // ------------------------------------------------------------
   // touchscreen linearization and clipping
   // ------------------------------------------------------------
   function automatic logic [9:0] lin_axis(input logic [15:0] raw, input logic [15:0] ofs,
                                           input logic [7:0] clip, input logic [7:0] seg [NSEG],
                                           input logic screen);
      logic [16:0] diff;
      logic [9:0]  d;
      logic [3:0]  idx;
      logic [13:0] acc;
      logic [13:0] frac;
      logic [9:0]  v;
      logic [9:0]  lo;
      logic [9:0]  hi;
      diff = {1'b0, raw} - {1'b0, ofs};
      if (diff[16])
         d = 10'h000;
      else if (diff[15:10] != 6'h00)
         d = COORD_MAX;
      else
         d = diff[9:0];
      idx  = d[9:6];
      acc  = 14'h0000;
      for (int i = 0; i < NSEG; i++)
         if (4'(i) < idx)
            acc = acc + 14'(seg[i]);
      frac = 14'(({8'h00, d[5:0]} * {6'h00, seg[idx]}) >> SEG_SHIFT);
      acc  = acc + frac;
      v    = (acc > 14'(COORD_MAX)) ? COORD_MAX : acc[9:0];
      if (!screen)
         v = raw[9:0];
      lo = {2'b00, clip};
      hi = COORD_MAX - lo;
      if (v < lo)
         v = lo;
      else if (v > hi)
         v = hi;
      return v;
   endfunction

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pos_x      <= 10'h000;
         pos_y      <= 10'h000;
         pos_update <= 1'b0;
      end else if (clk_en) begin
         pos_update <= coord_valid;
         if (coord_valid) begin
            pos_x <= lin_axis(raw_x, ofsx_q, clipx_q, segx_q, coord_is_screen);
            pos_y <= lin_axis(raw_y, ofsy_q, clipy_q, segy_q, coord_is_screen);
         end
      end
   end

   // ------------------------------------------------------------
   // change line gating
   // ------------------------------------------------------------
   // only the change line is gated; readback path above ignores the mask
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn)
         change_req <= 1'b0;
      else if (clk_en)
         change_req <= |(status_change & evmask_q[6:0]);
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   sequence s_under_acq(int c); clk_en && acq_strobe && !ch_over_thr[c] && !host_recal[c]; endsequence

   a_integ_clear: assert property (s_under_acq(0) |=> !ch_detect[0])
      else $error("detect survived an under-threshold acquisition");
   a_short_limit: assert property (clk_en && acq_strobe && !ch_detect[1] && object_touched
                                   && ch_on_object[1] && ch_over_thr[1] && !host_recal[1]
                                   && g_ch[1].integ_q + 8'd1 == short_integrator_limit_q && short_integrator_limit_q != 8'h00
                                   |=> ch_detect[1])
      else $error("short limit did not qualify detection");
   a_host_recal: assert property (clk_en && host_recal[1] |=> ch_recal[1] && !ch_detect[1])
      else $error("host recal not honoured");
   a_guard_norecal: assert property (clk_en && ch_guard[1] && !host_recal[1] |=> !ch_recal[1])
      else $error("guard channel recalibrated");
   a_never_recal: assert property (recal_q == 8'h00 && !host_recal[0] && clk_en |=> !ch_recal[0])
      else $error("recal with infinite delay");
   a_drift_hold: assert property (clk_en && |new_detect |=> hold_q == $past(dhold_q))
      else $error("drift hold not loaded");
   a_drift_neg: assert property (ch_neg_cross[5] |-> !drift_enable[5])
      else $error("drift during negative crossing");
   a_clip_range: assert property (pos_update && coord_is_screen |-> pos_x >= {2'b00, clipx_q}
                                  && pos_x <= COORD_MAX - {2'b00, clipx_q})
      else $error("coordinate outside clip window");
   a_mask_gate: assert property (clk_en && (status_change & evmask_q[6:0]) == 7'h00 |=> !change_req)
      else $error("masked change raised change line");
   a_force_sum: assert property (clk_en ##1 clk_en && $stable(force_q)
                                 |-> force_off_pct >= force_on_pct)
      else $error("off threshold below on threshold");

endmodule

// File: hw/tdt_pkg.sv
package tdt_pkg;
   localparam int          NCH           = 48;
   localparam int          NSEG          = 16;
   localparam logic [9:0]  A_NORMAL_INTEGRATOR_LIMIT        = 10'h2A5;
   localparam logic [9:0]  A_SHORT_INTEGRATOR_LIMIT        = 10'h2A6;
   localparam logic [9:0]  A_RECAL       = 10'h2A7;
   localparam logic [9:0]  A_DHOLD       = 10'h2A8;
   localparam logic [9:0]  A_FORCE       = 10'h2A9;
   localparam logic [9:0]  A_CLIPX       = 10'h2AA;
   localparam logic [9:0]  A_CLIPY       = 10'h2AB;
   localparam logic [9:0]  A_OFSX_LO     = 10'h2AC;
   localparam logic [9:0]  A_OFSX_HI     = 10'h2AD;
   localparam logic [9:0]  A_SEGX        = 10'h2AE;
   localparam logic [9:0]  A_OFSY_LO     = 10'h2BE;
   localparam logic [9:0]  A_OFSY_HI     = 10'h2BF;
   localparam logic [9:0]  A_SEGY        = 10'h2C0;
   localparam logic [9:0]  A_DWELL       = 10'h2D0;
   localparam logic [9:0]  A_EVMASK      = 10'h2D1;
   localparam logic [7:0]  RST_NORMAL_INTEGRATOR_LIMIT      = 8'h04;
   localparam logic [7:0]  RST_SHORT_INTEGRATOR_LIMIT      = 8'h02;
   localparam logic [7:0]  RST_RECAL     = 8'h96;
   localparam logic [7:0]  RST_DHOLD     = 8'h14;
   localparam logic [7:0]  RST_FORCE     = 8'hFF;
   localparam logic [7:0]  RST_SEG       = 8'h40;
   localparam logic [7:0]  RST_DWELL     = 8'h00;
   localparam logic [7:0]  RST_EVMASK    = 8'hFF;
   localparam int          FORCE_ON_LSB  = 4;
   localparam int          SEG_SHIFT     = 6;
   localparam logic [9:0]  COORD_MAX     = 10'h3FF;
   localparam int          CLK_HZ        = 50_000_000;
   localparam int          TICK_MS       = 200;
   localparam int          TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
   localparam int          DWELL_HALF_NS = 500;
   localparam int          DWELL_HALF_CY = (DWELL_HALF_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int          DWELL_CODES   = 6;
   // force level in percent of supply, indexed by 4-bit code
   localparam logic [7:0]  FORCE_PCT [16] = '{8'h02, 8'h03, 8'h05, 8'h06, 8'h08, 8'h09, 8'h0B, 8'h0C,
                                              8'h0E, 8'h10, 8'h11, 8'h13, 8'h14, 8'h16, 8'h17, 8'h19};
   // dwell in half-microsecond units, per code, high and low speed
   localparam logic [3:0]  DWELL_HS [6]  = '{4'h2, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5};
   localparam logic [3:0]  DWELL_LS [6]  = '{4'h2, 4'h2, 4'h4, 4'h6, 4'h8, 4'hA};
endpackage

// File: verification/tdt_host_model.sv
module tdt_host_model
   import tdt_pkg::*;
(
   input  wire logic       clk_sys,
   output logic            reg_wr,
   output logic      [9:0] reg_addr,
   output logic      [7:0] reg_wdata,
   input  wire logic [7:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      reg_wr    = 1'b0;
      reg_addr  = 10'h000;
      reg_wdata = 8'h00;
   end

   // ------------------------------------------------------------
   // register access
   // ------------------------------------------------------------
   // a careful host never writes illegal values, so they are mended here
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      logic [7:0] v;
      v = d;
      if (a == A_DHOLD && v < 8'h02) v = 8'h02;
      if (((a >= A_SEGX && a < A_SEGX + 10'h010) || (a >= A_SEGY && a < A_SEGY + 10'h010)) && v == 8'h00) v = 8'h40;
      @(posedge clk_sys);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
      // released data must not look held
      reg_wdata <= ~v;
   endtask

   task automatic rd(input logic [9:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      #1;
      d = reg_rdata;
   endtask

   // dwell is returned to one microsecond after any sweep
   task automatic dwell_default();
      wr(A_DWELL, 8'h00);
   endtask
endmodule

// File: verification/touch_detect_tuning_logic_bench.sv
module touch_detect_tuning_logic_bench
   import tdt_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk_sys = 1'b0, resetn = 1'b0, clk_en = 1'b1, acq_strobe = 1'b0, object_touched = 1'b0;
   logic high_speed = 1'b0, coord_valid = 1'b0, coord_is_screen = 1'b0;
   logic [NCH-1:0] ch_over_thr = '0, ch_neg_cross = '0, ch_guard = '0, ch_on_object = '0, host_recal = '0;
   logic [NCH-1:0] ch_detect, ch_filter_run, ch_recal, drift_enable;
   logic [15:0]    raw_x = 16'h0000, raw_y = 16'h0000;
   logic [9:0]     reg_addr, pos_x, pos_y;
   logic [7:0]     reg_wdata, reg_rdata, force_on_pct, force_off_pct, dwell_cycles, v;
   logic [6:0]     status_change = 7'h00;
   logic           reg_wr, pos_update, change_req;
   int             num_errors = 0, n_tests = 0, n;

   localparam logic [9:0] RA [17] = '{A_NORMAL_INTEGRATOR_LIMIT, A_SHORT_INTEGRATOR_LIMIT, A_RECAL, A_DHOLD, A_FORCE, A_CLIPX, A_CLIPY, A_OFSX_LO,
      A_OFSX_HI, A_SEGX, A_SEGX + 10'h00F, A_OFSY_LO, A_OFSY_HI, A_SEGY, A_DWELL, A_EVMASK, 10'h2D2};
   localparam logic [7:0] RV [17] = '{RST_NORMAL_INTEGRATOR_LIMIT, RST_SHORT_INTEGRATOR_LIMIT, RST_RECAL, RST_DHOLD, RST_FORCE, 8'h00, 8'h00, 8'h00,
      8'h00, RST_SEG, RST_SEG, 8'h00, 8'h00, RST_SEG, RST_DWELL, RST_EVMASK, 8'h00};
   localparam logic [7:0] DW_HS [6] = '{8'h32, 8'h19, 8'h32, 8'h4B, 8'h64, 8'h7D};
   localparam logic [7:0] DW_LS [6] = '{8'h32, 8'h32, 8'h64, 8'h96, 8'hC8, 8'hFA};

   always #10 clk_sys = ~clk_sys;

   // short tick keeps recal and hold timing to a few dozen cycles
   tdt_core #(.TICK_CY(20)) dut (.clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en), .reg_wr(reg_wr),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .acq_strobe(acq_strobe),
      .ch_over_thr(ch_over_thr), .ch_neg_cross(ch_neg_cross), .ch_guard(ch_guard), .ch_on_object(ch_on_object),
      .object_touched(object_touched), .host_recal(host_recal), .ch_detect(ch_detect),
      .ch_filter_run(ch_filter_run), .ch_recal(ch_recal), .drift_enable(drift_enable),
      .force_on_pct(force_on_pct), .force_off_pct(force_off_pct), .high_speed(high_speed),
      .dwell_cycles(dwell_cycles), .coord_valid(coord_valid), .coord_is_screen(coord_is_screen), .raw_x(raw_x),
      .raw_y(raw_y), .pos_x(pos_x), .pos_y(pos_y), .pos_update(pos_update), .status_change(status_change),
      .change_req(change_req));

   tdt_host_model host (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks=%0d errors=%0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic acq(input logic [NCH-1:0] over);
      @(posedge clk_sys);
      acq_strobe  <= 1'b1;
      ch_over_thr <= over;
      @(posedge clk_sys);
      acq_strobe  <= 1'b0;
      #1;
   endtask

   task automatic coord(input logic scr, input logic [15:0] x, input logic [15:0] y);
      @(posedge clk_sys);
      coord_valid     <= 1'b1;
      coord_is_screen <= scr;
      raw_x           <= x;
      raw_y           <= y;
      @(posedge clk_sys);
      coord_valid     <= 1'b0;
      #1;
      check(pos_update, 1'b1);
   endtask

   task automatic status(input logic [6:0] s, input logic exp);
      @(posedge clk_sys);
      status_change <= s;
      @(posedge clk_sys);
      status_change <= 7'h00;
      #1;
      check(change_req, exp);
   endtask

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      repeat (20) @(posedge clk_sys);
      resetn <= 1'b1;
      @(posedge clk_sys);
      #1;
      for (int i = 0; i < 17; i++) begin
         host.rd(RA[i], v);
         check(v, RV[i]);
      end
      check(force_on_pct, 8'h19);
      check(force_off_pct, 8'h32);
      check(dwell_cycles, 8'h32);
      repeat (3) acq(48'h1);
      check(ch_detect[0], 1'b0);
      acq(48'h0);
      repeat (3) acq(48'h1);
      check(ch_detect[0], 1'b0);
      acq(48'h1);
      check(ch_detect[0], 1'b1);
      check(drift_enable[5], 1'b0);
      acq(48'h0);
      check(ch_detect[0], 1'b0);
      ch_on_object <= 48'h2;
      acq(48'h2);
      check(ch_filter_run[1], 1'b0);
      acq(48'h2);
      check(ch_filter_run[1], 1'b1);
      check(ch_detect[1], 1'b0);
      acq(48'h0);
      object_touched <= 1'b1;
      repeat (2) acq(48'h2);
      check(ch_detect[1], 1'b1);
      acq(48'h0);
      object_touched <= 1'b0;
      ch_on_object   <= 48'h0;
      // auto recal on a plain channel, guard channel must survive
      host.wr(A_RECAL, 8'h02);
      ch_guard <= 48'h2;
      repeat (4) acq(48'h3);
      n = 0;
      while (ch_recal[0] !== 1'b1 && n < 80) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      check(n <= 42, 1'b1);
      @(posedge clk_sys);
      #1;
      check(ch_detect[0], 1'b0);
      repeat (60) @(posedge clk_sys);
      #1;
      check(ch_detect[1], 1'b1);
      host_recal <= 48'h2;
      @(posedge clk_sys);
      host_recal <= 48'h0;
      #1;
      check(ch_recal[1], 1'b1);
      host.wr(A_RECAL, 8'h00);
      repeat (4) acq(48'h1);
      check(ch_detect[0], 1'b1);
      repeat (100) @(posedge clk_sys);
      #1;
      check(ch_detect[0], 1'b1);
      host.rd(A_RECAL, v);
      check(v, 8'h00);
      acq(48'h0);
      ch_guard <= 48'h0;
      // drift hold after a fresh detection
      host.wr(A_DHOLD, 8'h02);
      repeat (4) acq(48'h1);
      acq(48'h0);
      check(drift_enable[5], 1'b0);
      repeat (70) @(posedge clk_sys);
      #1;
      check(drift_enable[5], 1'b1);
      @(posedge clk_sys);
      ch_neg_cross <= 48'h20;
      #1;
      check(drift_enable[5], 1'b0);
      host.wr(A_FORCE, 8'h5A);
      @(posedge clk_sys);
      #1;
      check({force_on_pct, force_off_pct}, 16'h091A);
      host.wr(A_FORCE, 8'h00);
      @(posedge clk_sys);
      #1;
      check({force_on_pct, force_off_pct}, 16'h0204);
      for (int m = 0; m < 2; m++) for (int c = 0; c < 6; c++) begin
         @(posedge clk_sys);
         high_speed <= m[0];
         host.wr(A_DWELL, 8'(c));
         @(posedge clk_sys);
         #1;
         check(dwell_cycles, m[0] ? DW_HS[c] : DW_LS[c]);
      end
      host.dwell_default();
      coord(1'b1, 16'h0123, 16'h02F0);
      check({6'h00, pos_x, pos_y}, {6'h00, 10'h123, 10'h2F0});
      host.wr(A_CLIPX, 8'h10);
      coord(1'b1, 16'h0005, 16'h03FC);
      check({6'h00, pos_x, pos_y}, {6'h00, 10'h010, 10'h3FC});
      coord(1'b1, 16'h03FC, 16'h0000);
      check(pos_x, 10'h3EF);
      host.wr(A_CLIPX, 8'h00);
      host.wr(A_OFSX_HI, 8'h01);
      coord(1'b1, 16'h0150, 16'h0000);
      check(pos_x, 10'h050);
      coord(1'b1, 16'h0080, 16'h0000);
      check(pos_x, 10'h000);
      host.wr(A_OFSX_HI, 8'h00);
      host.wr(A_SEGY, 8'h20);
      coord(1'b1, 16'h0000, 16'h0020);
      check(pos_y, 10'h010);
      coord(1'b1, 16'h0000, 16'h0050);
      check(pos_y, 10'h030);
      coord(1'b0, 16'h0000, 16'h0020);
      check(pos_y, 10'h020);
      host.wr(A_EVMASK, 8'h01);
      status(7'h02, 1'b0);
      status(7'h01, 1'b1);
      host.rd(A_EVMASK, v);
      check(v, 8'h01);
      // frozen clock enable: writes and acquisitions must leave no trace
      @(posedge clk_sys);
      clk_en <= 1'b0;
      host.wr(A_EVMASK, 8'h7F);
      repeat (4) acq(48'h1);
      host.rd(A_EVMASK, v);
      check({ch_detect[0], v}, 16'h0001);
      @(posedge clk_sys);
      clk_en <= 1'b1;
      repeat (3) acq(48'h1);
      check(ch_detect[0], 1'b0);
      acq(48'h1);
      check(ch_detect[0], 1'b1);
      tally_and_finish();
   end

   // whole run is a few hundred cycles
   initial begin
      repeat (20000) @(posedge clk_sys);
      num_errors++;
      tally_and_finish();
   end
endmodule
